// file: logic/srgsb_map.svh
// Register indices, field positions and reset values of the rate generator subbank
`ifndef SRGSB_MAP_SVH
`define SRGSB_MAP_SVH
`define SRGSB_IDX_SERIAL_CTRL_1    4'h0
`define SRGSB_IDX_SERIAL_CTRL_2    4'h1
`define SRGSB_IDX_RX_CTRL_1        4'h2
`define SRGSB_IDX_RX_CTRL_2        4'h3
`define SRGSB_IDX_TX_CTRL_1        4'h4
`define SRGSB_IDX_TX_CTRL_2        4'h5
`define SRGSB_IDX_RATE_GEN_1       4'h6
`define SRGSB_IDX_RATE_GEN_2       4'h7
`define SRGSB_IDX_MULTICHAN_1      4'h8
`define SRGSB_IDX_MULTICHAN_2      4'h9
`define SRGSB_IDX_RX_CHAN_EN_A     4'hA
`define SRGSB_IDX_RX_CHAN_EN_B     4'hB
`define SRGSB_IDX_TX_CHAN_EN_A     4'hC
`define SRGSB_IDX_TX_CHAN_EN_B     4'hD
`define SRGSB_IDX_PIN_CTRL         4'hE
`define SRGSB_NUM_REGS             15
// Memory locations of the three port instances
`define SRGSB_ADDR_PORT0           8'h39
`define SRGSB_ADDR_PORT1           8'h49
`define SRGSB_ADDR_PORT2           8'h35
// Field positions in rate_gen_2
`define SRGSB_RG2_RESYNC_BIT       15
`define SRGSB_RG2_EDGE_BIT         14
`define SRGSB_RG2_REF_MODE_BIT     13
`define SRGSB_RG2_FSYNC_MODE_BIT   12
`define SRGSB_RG2_PERIOD_MSB       11
`define SRGSB_RG2_PERIOD_LSB       0
// Field positions in pin_ctrl
`define SRGSB_PC_REF_MODE_EXT_BIT  7
`define SRGSB_PC_TX_FSYNC_INT_BIT  11
// Reset values
`define SRGSB_REG_RESET            16'h0000
`define SRGSB_PTR_RESET            4'h0
`define SRGSB_PERIOD_RESET         12'h000
`endif

// file: logic/srgsb_pkg.sv
// Types shared by the rate generator subbank design
package srgsb_pkg;
    typedef enum logic [1:0] {
        SRGSB_REF_EXT_PIN = 2'b00,
        SRGSB_REF_CPU     = 2'b01,
        SRGSB_REF_RX_PIN  = 2'b10,
        SRGSB_REF_TX_PIN  = 2'b11
    } srgsb_ref_e;

    typedef struct packed {
        logic        resync;
        logic        edge_fall;
        logic        ref_mode;
        logic        fsync_mode;
        logic [11:0] period;
    } srgsb_rg2_s;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } srgsb_bus_s;

    typedef struct packed {
        logic rx_clock;
        logic tx_clock;
        logic ext_ref_clock;
        logic rx_frame_sync;
    } srgsb_pins_s;
endpackage : srgsb_pkg

// file: logic/srgsb_top.sv
// Sample rate generator with subbank access to the serial port control registers
// Behaviour
// - Resync honoured only with external pin reference
// - Resync clear: generator clock free running
// - Resync set: realign, frame sync after rx sync
// - Resync set: period from external frame syncs
// - Edge select applies only to external pin
// - Ext mode zero: external pin or CPU
// - Ext mode one: rx clock or tx clock
// - Tx fsync mode only when internally generated
// - Mode clear: tx sync on data copy
// - Mode set: tx sync from generator sync
// - Twelve-bit frame period, 1 to 4096
// - Pointer register selects one control register
// - Data register accesses selected register
// - Indices 0 to 14 map in order
// - Each instance has its own data address
`timescale 1ns/1ps
`include "srgsb_map.svh"
module srgsb_top
    import srgsb_pkg::*;
#(
    parameter logic [7:0] DATA_ADDR = `SRGSB_ADDR_PORT0,
    parameter logic [7:0] PTR_ADDR  = 8'h38,
    parameter int         DIV_W     = 8
) (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    // Memory-mapped access
    input  wire srgsb_bus_s  bus_in,
    output logic [15:0]      rdata_out,
    output logic             rack_out,
    // Serial pins
    input  wire srgsb_pins_s pins_in,
    input  wire logic        tx_copy_in,
    output logic             gen_clock_out,
    output logic             gen_frame_sync_out,
    output logic             tx_frame_sync_out,
    output logic             tx_frame_sync_oe_out
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [15:0]                regs_ff [`SRGSB_NUM_REGS];
    logic [3:0]                 subbank_pointer_ff;
    logic                       ptr_hit;
    logic                       data_hit;
    logic                       ptr_valid;
    logic                       ptr_wr;
    logic                       data_wr;
    logic                       ptr_rd;
    logic                       data_rd;
    logic [`SRGSB_NUM_REGS-1:0] reg_we;
    logic [15:0]                rd_word;

    // Index check used by the read source; the write enables compare each index directly
    function automatic logic index_ok(input logic [3:0] idx);
        index_ok = (idx <= `SRGSB_IDX_PIN_CTRL);
    endfunction : index_ok

    assign ptr_hit   = bus_in.sel && (bus_in.addr == PTR_ADDR);
    assign data_hit  = bus_in.sel && (bus_in.addr == DATA_ADDR);
    // indices beyond the last map nowhere
    assign ptr_valid = index_ok(subbank_pointer_ff);
    assign ptr_wr    = ptr_hit && bus_in.wr;
    assign data_wr   = data_hit && bus_in.wr;
    assign ptr_rd    = ptr_hit && bus_in.rd;
    assign data_rd   = data_hit && bus_in.rd;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            subbank_pointer_ff <= `SRGSB_PTR_RESET;
        end else if (ptr_wr) begin
            subbank_pointer_ff <= bus_in.wdata[3:0];
        end
    end

    // one enable per index; a pointer past the last register
    // matches none, so such a write is dropped
    always_comb begin
        reg_we = '0;
        for (int i = 0; i < `SRGSB_NUM_REGS; i++) begin
            reg_we[i] = data_wr && (subbank_pointer_ff == 4'(i));
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < `SRGSB_NUM_REGS; i++) begin
                regs_ff[i] <= `SRGSB_REG_RESET;
            end
        end else begin
            for (int i = 0; i < `SRGSB_NUM_REGS; i++) begin
                if (reg_we[i]) begin
                    regs_ff[i] <= bus_in.wdata;
                end
            end
        end
    end

    // read source; a pointer past the last register reads zero
    always_comb begin
        if (ptr_rd) begin
            rd_word = {12'h000, subbank_pointer_ff};
        end else if (ptr_valid) begin
            rd_word = regs_ff[subbank_pointer_ff];
        end else begin
            rd_word = `SRGSB_REG_RESET;
        end
    end

    // registered read data, held until the next read
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= `SRGSB_REG_RESET;
        end else if (ptr_rd || data_rd) begin
            rdata_out <= rd_word;
        end
    end

    // Acknowledge one cycle after any read hit
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rack_out <= 1'b0;
        end else begin
            rack_out <= ptr_rd || data_rd;
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    srgsb_rg2_s rg2;
    logic       ref_mode_ext;
    logic       tx_fsync_internal;
    srgsb_ref_e ref_sel;

    assign rg2               = srgsb_rg2_s'(regs_ff[`SRGSB_IDX_RATE_GEN_2]);
    assign ref_mode_ext      = regs_ff[`SRGSB_IDX_PIN_CTRL][`SRGSB_PC_REF_MODE_EXT_BIT];
    assign tx_fsync_internal = regs_ff[`SRGSB_IDX_PIN_CTRL][`SRGSB_PC_TX_FSYNC_INT_BIT];
    assign ref_sel      = srgsb_ref_e'({ref_mode_ext, rg2.ref_mode});

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    srgsb_pins_s pins_meta_ff;
    srgsb_pins_s pins_sync_ff;
    srgsb_pins_s pins_prev_ff;

    // Two-stage synchroniser; only the second stage feeds any logic
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pins_meta_ff <= '0;
            pins_sync_ff <= '0;
        end else begin
            pins_meta_ff <= pins_in;
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // Edge history resets to the idle low level, so no false edge after reset
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pins_prev_ff <= '0;
        end else begin
            pins_prev_ff <= pins_sync_ff;
        end
    end

    function automatic logic edge_of(input logic cur, input logic prev, input logic fall);
        edge_of = fall ? (prev && !cur) : (cur && !prev);
    endfunction : edge_of

    // ----------------------------------------------------------------
    // Reference tick
    // ----------------------------------------------------------------
    logic ref_tick;
    logic ext_pin_ref;
    logic rx_fs_edge;

    assign ext_pin_ref = (ref_sel == SRGSB_REF_EXT_PIN);
    // Receive frame sync counts on its rising edge only
    assign rx_fs_edge  = edge_of(pins_sync_ff.rx_frame_sync, pins_prev_ff.rx_frame_sync, 1'b0);

    // Receive and transmit clock pins have no edge select; rising edge is used
    always_comb begin
        unique case (ref_sel)
            // edge select on the external pin only
            SRGSB_REF_EXT_PIN: ref_tick = edge_of(pins_sync_ff.ext_ref_clock,
                                                  pins_prev_ff.ext_ref_clock, rg2.edge_fall);
            SRGSB_REF_CPU:     ref_tick = 1'b1;
            SRGSB_REF_RX_PIN:  ref_tick = edge_of(pins_sync_ff.rx_clock,
                                                  pins_prev_ff.rx_clock, 1'b0);
            SRGSB_REF_TX_PIN:  ref_tick = edge_of(pins_sync_ff.tx_clock,
                                                  pins_prev_ff.tx_clock, 1'b0);
        endcase
    end

    // ----------------------------------------------------------------
    // Generator clock and frame sync
    // ----------------------------------------------------------------
    logic resync_on;
    logic gen_clk_rise;
    logic [11:0] frame_cnt_ff;
    logic        armed_ff;

    // Frame boundary test, shared by the counter wrap and the sync pulse
    function automatic logic period_end(input logic [11:0] cnt, input logic [11:0] period);
        period_end = (cnt >= period);
    endfunction : period_end

    // resync only with external pin reference
    assign resync_on = rg2.resync && ext_pin_ref;

    // The divide ratio field lives outside this block, so the generator
    // clock toggles once per reference tick; one tick high, one low.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gen_clock_out <= 1'b0;
        end else if (resync_on && rx_fs_edge) begin
            gen_clock_out <= 1'b0;
        end else if (ref_tick) begin
            gen_clock_out <= !gen_clock_out;
        end
    end

    assign gen_clk_rise = ref_tick && !gen_clock_out && !(resync_on && rx_fs_edge);

    // period counter, field N gives N+1 clocks
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_cnt_ff <= `SRGSB_PERIOD_RESET;
        end else if (resync_on) begin
            frame_cnt_ff <= `SRGSB_PERIOD_RESET;
        end else if (gen_clk_rise) begin
            frame_cnt_ff <= period_end(frame_cnt_ff, rg2.period) ? `SRGSB_PERIOD_RESET
                                                                  : frame_cnt_ff + 12'h001;
        end
    end

    // frame sync issued on the first clock after the rx sync
    // Arming lasts until the next generator rise: one pulse per rx sync
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            armed_ff <= 1'b0;
        end else if (!resync_on) begin
            armed_ff <= 1'b0;
        end else if (rx_fs_edge) begin
            armed_ff <= 1'b1;
        end else if (gen_clk_rise) begin
            armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gen_frame_sync_out <= 1'b0;
        end else if (resync_on) begin
            gen_frame_sync_out <= armed_ff && gen_clk_rise;
        end else begin
            gen_frame_sync_out <= gen_clk_rise && period_end(frame_cnt_ff, rg2.period);
        end
    end

    // ----------------------------------------------------------------
    // Transmit frame sync
    // ----------------------------------------------------------------
    logic nxt_tx_frame_sync;

    // mode applies only when internally generated
    always_comb begin
        if (!tx_fsync_internal) begin
            nxt_tx_frame_sync = 1'b0;
        end else if (rg2.fsync_mode) begin
            nxt_tx_frame_sync = gen_frame_sync_out;
        end else begin
            nxt_tx_frame_sync = tx_copy_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_frame_sync_out <= 1'b0;
        end else begin
            tx_frame_sync_out <= nxt_tx_frame_sync;
        end
    end

    // Pin is driven only while its frame sync is generated in this block
    assign tx_frame_sync_oe_out = tx_fsync_internal;

endmodule : srgsb_top

// file: test/srgsb_properties.sv
// Port checks for the rate generator subbank
`timescale 1ns/1ps
module srgsb_properties
    import srgsb_pkg::*;
#(
    parameter logic [7:0] DATA_ADDR = 8'h39,
    parameter logic [7:0] PTR_ADDR  = 8'h38
) (
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    input  wire srgsb_bus_s  bus_in,
    input  wire logic [15:0] rdata_out,
    input  wire logic        rack_out,
    input  wire srgsb_pins_s pins_in,
    input  wire logic        tx_copy_in,
    input  wire logic        gen_clock_out,
    input  wire logic        gen_frame_sync_out,
    input  wire logic        tx_frame_sync_out,
    input  wire logic        tx_frame_sync_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // ------------------------------------------------------------
    // Shadow registers and frame interval counter
    // ------------------------------------------------------------
    logic [3:0]  ptr_ff;
    logic [15:0] rg2_ff;
    logic [15:0] pc_ff;
    logic [13:0] cnt_ff;
    logic        ok_ff;
    wire logic rd_hit = bus_in.sel && bus_in.rd && bus_in.addr inside {PTR_ADDR, DATA_ADDR};
    wire logic wr_d   = bus_in.sel && bus_in.wr && bus_in.addr == DATA_ADDR;
    wire logic cpu    = !pc_ff[7] && rg2_ff[13];
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_ff <= 4'h0;
            rg2_ff <= 16'h0000;
            pc_ff  <= 16'h0000;
        end else if (bus_in.sel && bus_in.wr && bus_in.addr == PTR_ADDR) begin
            ptr_ff <= bus_in.wdata[3:0];
        end else if (wr_d && ptr_ff == 4'h7) begin
            rg2_ff <= bus_in.wdata;
        end else if (wr_d && ptr_ff == 4'hE) begin
            pc_ff <= bus_in.wdata;
        end
    end
    // Interval only trusted once a frame sync followed the last config write
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_ff <= 14'h0000;
            ok_ff  <= 1'b0;
        end else begin
            cnt_ff <= gen_frame_sync_out ? 14'h0000 : cnt_ff + 14'h0001;
            ok_ff  <= !wr_d && (ok_ff || gen_frame_sync_out);
        end
    end
    sequence s_copy;
        tx_copy_in && pc_ff[11] && !rg2_ff[12];
    endsequence
    property p_rack_hit; rd_hit |=> rack_out; endproperty
    a_rack_hit: assert property (p_rack_hit) else $error("no ack on read");
    property p_rack_miss; bus_in.sel && !rd_hit |=> !rack_out; endproperty
    a_rack_miss: assert property (p_rack_miss) else $error("ack on miss");
    property p_ptr_rd; rd_hit && bus_in.addr == PTR_ADDR |=> rdata_out[3:0] == $past(ptr_ff);
    endproperty
    a_ptr_rd: assert property (p_ptr_rd) else $error("pointer readback");
    property p_reg_rd;
        rd_hit && bus_in.addr == DATA_ADDR && ptr_ff inside {4'h7, 4'hE}
        |=> rdata_out == ($past(ptr_ff) == 4'h7 ? $past(rg2_ff) : $past(pc_ff));
    endproperty
    a_reg_rd: assert property (p_reg_rd) else $error("register readback");
    property p_oe; tx_frame_sync_oe_out == pc_ff[11]; endproperty
    a_oe: assert property (p_oe) else $error("sync enable");
    property p_tx_gen; rg2_ff[12] && pc_ff[11] && gen_frame_sync_out |=> tx_frame_sync_out;
    endproperty
    a_tx_gen: assert property (p_tx_gen) else $error("tx sync from gen");
    property p_tx_copy; s_copy |=> tx_frame_sync_out; endproperty
    a_tx_copy: assert property (p_tx_copy) else $error("tx sync on copy");
    property p_period; ok_ff && cpu && gen_frame_sync_out |-> cnt_ff == {1'b0, rg2_ff[11:0], 1'b1};
    endproperty
    a_period: assert property (p_period) else $error("frame interval");
    property p_late; ok_ff && cpu |-> cnt_ff <= {1'b0, rg2_ff[11:0], 1'b1}; endproperty
    a_late: assert property (p_late) else $error("frame sync late");
    property p_cpu; cpu && $past(cpu) && $past(cpu, 2) |-> gen_clock_out != $past(gen_clock_out);
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu ref toggle");
endmodule : srgsb_properties

// file: test/srgsb_pins_model.sv
// Far-side serial device: free running clocks and a requested frame sync
`timescale 1ns/1ps
module srgsb_pins_model
    import srgsb_pkg::*;
(
    input  wire logic  core_clk_in,
    input  wire logic  run_in,
    input  wire logic  sync_req_in,
    output srgsb_pins_s pins_out
);
    int n = 0;
    initial pins_out = '0;
    // Three unrelated clock rates so a wrong reference shows as a wrong rate
    always @(negedge core_clk_in) begin
        n <= run_in ? n + 1 : 0;
        pins_out.ext_ref_clock <= run_in && (n % 6 < 3);
        pins_out.rx_clock      <= run_in && (n % 8 < 4);
        pins_out.tx_clock      <= run_in && (n % 10 < 5);
        pins_out.rx_frame_sync <= sync_req_in;
    end
endmodule : srgsb_pins_model

// file: test/srgsb_top_tb.sv
// Self-checking bench for the rate generator subbank
`timescale 1ns/1ps
`include "srgsb_map.svh"
module srgsb_top_tb;
    import srgsb_pkg::*;
    localparam logic [7:0] PA = 8'h38;
    localparam logic [7:0] DA = `SRGSB_ADDR_PORT1;
    logic core_clk = 0, resetn = 0, tx_copy = 0, run = 0, sync_req = 0;
    logic rack, gclk, gfs, txfs, txoe, gfs_seen;
    logic [15:0] rdata;
    srgsb_bus_s  bus = '0;
    srgsb_pins_s pins;
    int          err_total = 0, checks_done = 0, r, f, tp[4] = '{6, 1, 8, 10};
    logic [31:0] seed = 32'h93F3;
    always #50 core_clk = !core_clk;
    srgsb_top #(.DATA_ADDR(DA), .PTR_ADDR(PA), .DIV_W(8)) srgsb_top_i (
        .core_clk_in(core_clk), .resetn_in(resetn), .bus_in(bus), .rdata_out(rdata),
        .rack_out(rack), .pins_in(pins), .tx_copy_in(tx_copy), .gen_clock_out(gclk),
        .gen_frame_sync_out(gfs), .tx_frame_sync_out(txfs), .tx_frame_sync_oe_out(txoe));
    srgsb_pins_model srgsb_pins_model_i (.core_clk_in(core_clk), .run_in(run),
        .sync_req_in(sync_req), .pins_out(pins));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [15:0] near(input int got, input int exp);
        return (got >= exp - 1 && got <= exp + 1) ? 16'h0001 : 16'h0000;
    endfunction : near
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        bus <= '{1'b1, w, !w, a, d};
        @(negedge core_clk);
        bus <= '0;
    endtask : acc
    task automatic wreg(input logic [3:0] i, input logic [15:0] d);
        acc(1'b1, PA, {12'h000, i});
        acc(1'b1, DA, d);
    endtask : wreg
    task automatic watch(input int cyc);
        logic p;
        r = 0;
        f = 0;
        p = gclk;
        repeat (cyc) begin
            @(negedge core_clk);
            r += int'(gclk && !p);
            f += int'(gfs);
            p = gclk;
        end
    endtask : watch
    task automatic summarize;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            if (i >= 15) wreg(4'(i - 15), seed[15:0]);
            acc(1'b1, PA, 16'(i % 15));
            acc(1'b0, DA, 16'h0000);
            chk(rdata, i < 15 ? 16'h0000 : seed[15:0]);
        end
        acc(1'b0, PA, 16'h0000);
        chk({12'h000, rdata[3:0]}, 16'h000E);
        acc(1'b0, `SRGSB_ADDR_PORT0, 16'h0000);
        chk({15'h0, rack}, 16'h0000);
        $display("register test done");
        run <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wreg(4'hE, {8'h00, 1'(k >> 2), 7'h00});
            wreg(4'h7, {1'b0, 1'(k), 1'(k >> 1), 13'h0000});
            watch(240);
            chk(near(r, 240 / (2 * tp[k >> 1])), 16'h0001);
            chk(near(f, r), 16'h0001);
        end
        wreg(4'hE, 16'h0800);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            tp[k] = k == 3 ? 4095 : (k == 2 ? int'(seed[3:0]) : k);
            wreg(4'h7, {seed[4], 3'b011, 12'(tp[k])});
            watch(6 * (tp[k] + 1) + 20);
            chk(near(f, (6 * (tp[k] + 1) + 20) / (2 * (tp[k] + 1))), 16'h0001);
        end
        $display("rate test done");
        for (int k = 0; k < 4; k++) begin
            wreg(4'hE, {4'h0, 1'(k), 11'h000});
            wreg(4'h7, {3'b001, 1'(k >> 1), 12'hFFF});
            chk({15'h0, txoe}, 16'(k & 1));
            @(negedge core_clk) tx_copy <= 1'b1;
            gfs_seen = gfs;
            @(negedge core_clk) tx_copy <= 1'b0;
            chk({15'h0, txfs}, {15'h0, k == 1 || (k == 3 && gfs_seen)});
        end
        $display("tx sync test done");
        wreg(4'hE, 16'h0000);
        wreg(4'h7, 16'h8000);
        repeat (30) @(negedge core_clk);
        watch(200);
        chk(16'(f), 16'h0000);
        sync_req <= 1'b1;
        repeat (2) @(negedge core_clk);
        sync_req <= 1'b0;
        watch(40);
        chk(16'(f), 16'h0001);
        wreg(4'h7, 16'h0000);
        watch(120);
        chk(near(f, 10), 16'h0001);
        $display("sync test done");
        summarize();
    end
endmodule : srgsb_top_tb
bind srgsb_top srgsb_properties #(.DATA_ADDR(DATA_ADDR), .PTR_ADDR(PTR_ADDR)) srgsb_properties_i (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .rack_out(rack_out), .pins_in(pins_in), .tx_copy_in(tx_copy_in),
    .gen_clock_out(gen_clock_out), .gen_frame_sync_out(gen_frame_sync_out),
    .tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe_out(tx_frame_sync_oe_out));
